/* core/psr_pkg.sv */
// constants and types shared by the pressure status readout block
// ----------------------------------------------------------------------------
// How it works
// - start then stop with no clock pulse fails the following transaction.
// - repeated start during a transfer fails the next transaction.
// - diagnostic code sits in the two top bits of the first byte.
// - code 00 means fresh normal data, 01 means command mode.
// - code 10 means data already fetched since the last measurement.
// - fetch before the first measurement completes returns the stale code.
// - code 11 reports any signature, bridge or source fault.
// - fault seen in next measurement, reported in the fetch after it.
// - diagnostic code stays latched until fault removed and power-on reset.
// - answer only the configured seven bit address with read bit set.
// - bytes go status plus pressure high, pressure low, temperature high, low.
// ----------------------------------------------------------------------------
package psr_pkg;

  // bus addressing
  localparam logic [6:0] PSR_ADDR_DEFAULT = 7'h28;

  // status codes in the top bits of the first byte
  localparam logic [1:0] PSR_ST_NORMAL = 2'h0;
  localparam logic [1:0] PSR_ST_CMD    = 2'h1;
  localparam logic [1:0] PSR_ST_STALE  = 2'h2;
  localparam logic [1:0] PSR_ST_DIAG   = 2'h3;

  // data layout
  localparam int PSR_P_W    = 14;
  localparam int PSR_T_W    = 11;
  localparam int PSR_BYTE_W = 8;
  localparam int PSR_P_HI_W = 6;
  localparam int PSR_T_LO_W = 3;
  localparam int PSR_WORD_W = 1 + PSR_P_W + PSR_T_W;
  localparam int PSR_DIAG_B = PSR_WORD_W - 1;
  localparam int PSR_FIFO_DEPTH = 16;
  localparam logic [4:0] PSR_T_PAD = 5'h00;
  localparam logic [7:0] PSR_PAD_BYTE = 8'hff;

  // bit and byte counting
  localparam logic [3:0] PSR_BIT_CNT  = 4'h8;
  localparam logic [3:0] PSR_BIT_LAST = 4'h7;
  localparam logic [3:0] PSR_ACK_SEEN = 4'h1;
  localparam logic [2:0] PSR_IDX_P_HI = 3'h0;
  localparam logic [2:0] PSR_IDX_P_LO = 3'h1;
  localparam logic [2:0] PSR_IDX_T_HI = 3'h2;
  localparam logic [2:0] PSR_IDX_T_LO = 3'h3;
  localparam logic [2:0] PSR_IDX_MAX  = 3'h4;

  // link protocol states
  typedef enum logic [5:0] {
    PSR_S_IDLE = 6'h01,
    PSR_S_ADDR = 6'h02,
    PSR_S_AACK = 6'h04,
    PSR_S_TX   = 6'h08,
    PSR_S_RACK = 6'h10,
    PSR_S_IGN  = 6'h20
  } psr_state_t;

endpackage

/* core/psr_readout.sv */
// pressure status readout: measurement fifo, crossing and two-wire slave
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// measurement fifo
// ----------------------------------------------------------------------------
module psr_fifo #(
  parameter int WIDTH = psr_pkg::PSR_WORD_W,
  parameter int DEPTH = psr_pkg::PSR_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      count      <= next_count;
      // registered so the port comes from a flop
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // psr_fifo

// ----------------------------------------------------------------------------
// top: readout block
// ----------------------------------------------------------------------------
module psr_readout #(
  parameter logic [6:0] SLAVE_ADDR = psr_pkg::PSR_ADDR_DEFAULT,
  parameter int         DEPTH      = psr_pkg::PSR_FIFO_DEPTH
) (
  // clocks and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        clk_link_i,
  input  wire logic                        resetn_i,
  // measurement engine side
  input  wire logic                        meas_valid_i,
  output logic                             meas_ready_o,
  input  wire logic [psr_pkg::PSR_P_W-1:0] pressure_i,
  input  wire logic [psr_pkg::PSR_T_W-1:0] temp_i,
  input  wire logic                        cmd_mode_i,
  // fault detectors, sampled with each measurement
  input  wire logic                        nvm_sig_bad_i,
  input  wire logic                        bridge_open_i,
  input  wire logic                        bridge_short_i,
  input  wire logic                        source_lost_i,
  // two-wire pins
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_o
);
  localparam int WW = psr_pkg::PSR_WORD_W;

  // --------------------------------------------------------------------------
  // system domain: fifo and handshake source
  // --------------------------------------------------------------------------
  logic          any_fault;
  logic [WW-1:0] fifo_data;
  logic          fifo_valid;
  logic          fifo_ready;
  logic [WW-1:0] word_x;
  logic          req_tog;
  logic          ack_m;
  logic          ack_s;
  logic          ack_tog;

  // fault is caught with the measurement that saw it
  assign any_fault  = nvm_sig_bad_i | bridge_open_i | bridge_short_i | source_lost_i;
  assign fifo_ready = (req_tog == ack_s);

  psr_fifo #(
    .WIDTH (WW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_sys_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (meas_valid_i),
    .in_ready_o  (meas_ready_o),
    .in_data_i   ({any_fault, pressure_i, temp_i}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      ack_m <= ack_tog;
      ack_s <= ack_m;
    end
  end

  // word_x stays put until the link side acknowledges
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_x  <= '0;
      req_tog <= 1'b0;
    end else if (fifo_valid && fifo_ready) begin
      word_x  <= fifo_data;
      req_tog <= ~req_tog;
    end
  end

  // --------------------------------------------------------------------------
  // link domain: pin and level synchronisers
  // --------------------------------------------------------------------------
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic req_m, req_s;
  logic cmd_m, cmd_s;

  always_ff @(posedge clk_link_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {req_m, req_s}        <= 2'h0;
      {cmd_m, cmd_s}        <= 2'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
      {req_m, req_s}        <= {req_tog, req_m};
      {cmd_m, cmd_s}        <= {cmd_mode_i, cmd_m};
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

  // --------------------------------------------------------------------------
  // link domain: protocol
  // --------------------------------------------------------------------------
  psr_pkg::psr_state_t state;
  logic [7:0]          sh;
  logic [3:0]          cnt;
  logic [2:0]          idx;
  logic                poison;
  logic                scl_seen;
  logic                xfer;
  logic                load0;
  logic                fresh;
  logic                diag;
  logic [1:0]          status;
  logic [7:0]          next_byte;
  logic [psr_pkg::PSR_P_W-1:0] pkt_p;
  logic [psr_pkg::PSR_T_W-1:0] pkt_t;

  assign xfer  = (state == psr_pkg::PSR_S_AACK) || (state == psr_pkg::PSR_S_TX) ||
                 (state == psr_pkg::PSR_S_RACK) || ((state == psr_pkg::PSR_S_ADDR) && scl_seen);
  assign load0 = (state == psr_pkg::PSR_S_AACK) && scl_fall && !start_det && !stop_det;

  always_comb begin
    if (diag) begin
      status = psr_pkg::PSR_ST_DIAG;
    end else if (cmd_s) begin
      status = psr_pkg::PSR_ST_CMD;
    end else if (fresh) begin
      status = psr_pkg::PSR_ST_NORMAL;
    end else begin
      status = psr_pkg::PSR_ST_STALE;
    end
  end

  always_comb begin
    unique case (idx)
      psr_pkg::PSR_IDX_P_HI: next_byte = {status,
        pkt_p[psr_pkg::PSR_P_W-1 -: psr_pkg::PSR_P_HI_W]};
      psr_pkg::PSR_IDX_P_LO: next_byte = pkt_p[psr_pkg::PSR_BYTE_W-1:0];
      psr_pkg::PSR_IDX_T_HI: next_byte = pkt_t[psr_pkg::PSR_T_W-1 -: psr_pkg::PSR_BYTE_W];
      psr_pkg::PSR_IDX_T_LO: next_byte = {pkt_t[psr_pkg::PSR_T_LO_W-1:0], psr_pkg::PSR_T_PAD};
      default:               next_byte = psr_pkg::PSR_PAD_BYTE;
    endcase
  end

  always_ff @(posedge clk_link_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= psr_pkg::PSR_S_IDLE;
      sh    <= '0;
      cnt   <= '0;
      idx   <= '0;
    end else if (start_det) begin
      // a poisoned or mid-transfer start is the failing one
      state <= (poison || xfer) ? psr_pkg::PSR_S_IGN : psr_pkg::PSR_S_ADDR;
      cnt   <= '0;
      idx   <= '0;
    end else if (stop_det) begin
      state <= psr_pkg::PSR_S_IDLE;
    end else begin
      unique case (state)
        psr_pkg::PSR_S_ADDR: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && cnt == psr_pkg::PSR_BIT_CNT) begin
            cnt   <= '0;
            // reads only, to our own address
            state <= (sh == {SLAVE_ADDR, 1'b1}) ? psr_pkg::PSR_S_AACK : psr_pkg::PSR_S_IGN;
          end
        end
        psr_pkg::PSR_S_AACK: begin
          if (scl_fall) begin
            sh    <= next_byte;
            idx   <= psr_pkg::PSR_IDX_P_LO;
            state <= psr_pkg::PSR_S_TX;
          end
        end
        psr_pkg::PSR_S_TX: begin
          if (scl_fall) begin
            if (cnt == psr_pkg::PSR_BIT_LAST) begin
              cnt   <= '0;
              state <= psr_pkg::PSR_S_RACK;
            end else begin
              sh  <= {sh[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
        end
        psr_pkg::PSR_S_RACK: begin
          if (scl_rise) begin
            // nack ends the fetch; the master decides the length
            if (sda_s) begin
              state <= psr_pkg::PSR_S_IGN;
            end else begin
              cnt <= psr_pkg::PSR_ACK_SEEN;
            end
          end else if (scl_fall && cnt == psr_pkg::PSR_ACK_SEEN) begin
            cnt   <= '0;
            sh    <= next_byte;
            idx   <= (idx == psr_pkg::PSR_IDX_MAX) ? idx : idx + 3'h1;
            state <= psr_pkg::PSR_S_TX;
          end
        end
        psr_pkg::PSR_S_IDLE,
        psr_pkg::PSR_S_IGN: begin
          state <= state;
        end
      endcase
    end
  end

  // protocol departure tracking
  always_ff @(posedge clk_link_i or negedge resetn_i) begin
    if (!resetn_i) begin
      poison   <= 1'b0;
      scl_seen <= 1'b0;
    end else if (start_det) begin
      // a waiting poison is consumed by this start
      poison   <= xfer;
      scl_seen <= 1'b0;
    end else begin
      if (stop_det && state == psr_pkg::PSR_S_ADDR && !scl_seen) begin
        poison <= 1'b1;
      end
      if (scl_rise) begin
        scl_seen <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // link domain: packet, freshness and diagnostic latch
  // --------------------------------------------------------------------------
  logic take;

  // words land only between fetches so a packet never tears
  assign take = (req_s != ack_tog) &&
                ((state == psr_pkg::PSR_S_IDLE) || (state == psr_pkg::PSR_S_IGN));

  always_ff @(posedge clk_link_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pkt_p   <= '0;
      pkt_t   <= '0;
      ack_tog <= 1'b0;
    end else if (take) begin
      pkt_p   <= word_x[psr_pkg::PSR_DIAG_B-1 -: psr_pkg::PSR_P_W];
      pkt_t   <= word_x[psr_pkg::PSR_T_W-1:0];
      ack_tog <= req_s;
    end
  end

  always_ff @(posedge clk_link_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fresh <= 1'b0;
    end else if (take) begin
      fresh <= 1'b1;
    end else if (load0) begin
      fresh <= 1'b0;
    end
  end

  // only power-on reset clears it; a lasting fault re-latches with the next measurement
  always_ff @(posedge clk_link_i or negedge resetn_i) begin
    if (!resetn_i) begin
      diag <= 1'b0;
    end else if (take && word_x[psr_pkg::PSR_DIAG_B]) begin
      diag <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // link domain: pin drive
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_link_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b1;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_o <= !((state == psr_pkg::PSR_S_AACK) ||
                    ((state == psr_pkg::PSR_S_TX) && !sh[7]));
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_stop_poison;
    @(posedge clk_link_i) disable iff (!resetn_i)
    stop_det && !start_det && state == psr_pkg::PSR_S_ADDR && !scl_seen |=> poison;
  endproperty
  a_stop_poison: assert property (p_stop_poison)
    else $error("empty start-stop did not poison");

  property p_rstart;
    @(posedge clk_link_i) disable iff (!resetn_i)
    start_det && xfer |=> poison && state == psr_pkg::PSR_S_IGN;
  endproperty
  a_rstart: assert property (p_rstart)
    else $error("repeated start not treated as failure");

  property p_fail_next;
    @(posedge clk_link_i) disable iff (!resetn_i)
    start_det && poison && !xfer |=> !poison && state == psr_pkg::PSR_S_IGN;
  endproperty
  a_fail_next: assert property (p_fail_next)
    else $error("poisoned start was answered");

  property p_diag_code;
    @(posedge clk_link_i) disable iff (!resetn_i)
    load0 && diag |=> sh[7:6] == psr_pkg::PSR_ST_DIAG;
  endproperty
  a_diag_code: assert property (p_diag_code)
    else $error("fault code missing in first byte");

  property p_stale_code;
    @(posedge clk_link_i) disable iff (!resetn_i)
    load0 && !diag && !cmd_s && !fresh |=> sh[7:6] == psr_pkg::PSR_ST_STALE;
  endproperty
  a_stale_code: assert property (p_stale_code)
    else $error("stale code missing");

  property p_fresh_clear;
    @(posedge clk_link_i) disable iff (!resetn_i)
    load0 |=> !fresh ##1 (!fresh || $past(take));
  endproperty
  a_fresh_clear: assert property (p_fresh_clear)
    else $error("fresh mark survived a fetch");

  property p_diag_sticky;
    @(posedge clk_link_i) disable iff (!resetn_i)
    diag |=> diag [*8];
  endproperty
  a_diag_sticky: assert property (p_diag_sticky)
    else $error("diagnostic latch released");

  property p_addr_ack;
    @(posedge clk_link_i) disable iff (!resetn_i)
    $rose(state == psr_pkg::PSR_S_AACK) |-> $past(sh) == {SLAVE_ADDR, 1'b1} ##1 !sda_oe_o;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("ack without own read address");

endmodule // psr_readout

/* verif/psr_mst_model.sv */
// two-wire bus master model that fetches measurement packets
`timescale 1ns/10ps
module psr_mst_model #(
  parameter int Q_NS = 700
) (
  // bus pins, sda as a release flag for the open-drain wire
  output logic      scl_o,
  output logic      sda_rel_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end

  // also a repeated start from scl low; sda never moves in step with scl
  task automatic start();
    #(Q_NS);
    sda_rel_o = 1'b1;
    #(Q_NS);
    scl_o = 1'b1;
    #(Q_NS);
    sda_rel_o = 1'b0;
    #(Q_NS);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    #(Q_NS);
    sda_rel_o = 1'b0;
    #(Q_NS);
    scl_o = 1'b1;
    #(Q_NS);
    sda_rel_o = 1'b1;
    #(4*Q_NS);
  endtask

  // start and stop with scl held high throughout
  task automatic bare_start_stop();
    #(Q_NS);
    sda_rel_o = 1'b0;
    #(2*Q_NS);
    sda_rel_o = 1'b1;
    #(4*Q_NS);
  endtask

  task automatic bit_xfer(input logic b, output logic r);
    #(Q_NS);
    sda_rel_o = b;
    #(Q_NS);
    scl_o = 1'b1;
    #(Q_NS);
    r = sda_i;
    #(Q_NS);
    scl_o = 1'b0;
  endtask

  task automatic xfer_byte(input logic [7:0] w, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(w[i], r[i]);
    end
  endtask

  // bytes land in d, first byte highest; nack on the last wanted one
  task automatic fetch(input logic [7:0] a, input int n, output logic ack,
                       output logic [31:0] d);
    logic [7:0] b;
    logic       x;
    start();
    xfer_byte(a, b);
    bit_xfer(1'b1, x);
    ack = ~x;
    d = 32'h0000_0000;
    for (int k = 0; k < n && ack; k++) begin
      xfer_byte(8'hff, b);
      d = {d[23:0], b};
      bit_xfer(k == n - 1, x);
    end
    stop();
  endtask
endmodule // psr_mst_model

/* verif/tb.sv */
// self-checking bench of the pressure status readout block
`timescale 1ns/10ps
module tb;
  logic        clk_sys_i    = 1'b0;
  logic        clk_link_i   = 1'b0;
  logic        resetn_i     = 1'b0;
  logic        meas_valid_i = 1'b0;
  logic        cmd_mode_i   = 1'b0;
  logic [13:0] pressure_i   = 14'h0000;
  logic [10:0] temp_i       = 11'h000;
  logic [3:0]  fault        = 4'h0;
  logic        meas_ready_o;
  logic        scl;
  logic        sda_rel;
  logic        sda;
  logic        sda_o;
  logic        sda_oe_o;
  logic        ack;
  logic        tk;
  logic [31:0] d;
  logic [13:0] lp = 14'h0000;
  logic [10:0] lt = 11'h000;
  int          n_errors = 0;
  int          compares = 0;

  always #20 clk_sys_i = ~clk_sys_i;
  // rising link edges never meet rising system edges, so pin timing drifts freely
  always #32 clk_link_i = ~clk_link_i;
  // pull-up wire: low when either party pulls
  assign sda = sda_rel & (sda_oe_o | sda_o);

  psr_readout dut_u (
    .clk_sys_i(clk_sys_i), .clk_link_i(clk_link_i), .resetn_i(resetn_i),
    .meas_valid_i(meas_valid_i), .meas_ready_o(meas_ready_o), .pressure_i(pressure_i),
    .temp_i(temp_i), .cmd_mode_i(cmd_mode_i), .nvm_sig_bad_i(fault[0]),
    .bridge_open_i(fault[1]), .bridge_short_i(fault[2]), .source_lost_i(fault[3]),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  psr_mst_model mst_u (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda));

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] pk(input logic [1:0] s);
    return {s, lp, lt, 5'h00};
  endfunction

  task automatic push(input logic [13:0] p, input logic [10:0] t, output logic taken);
    @(posedge clk_sys_i);
    #1;
    pressure_i = p;
    temp_i = t;
    meas_valid_i = 1'b1;
    taken = meas_ready_o;
    @(posedge clk_sys_i);
    #1;
    meas_valid_i = 1'b0;
  endtask

  // push one word and let it cross to the link side
  task automatic meas(input logic [13:0] p, input logic [10:0] t);
    push(p, t, tk);
    chk(tk, 1'b1);
    lp = p;
    lt = t;
    repeat (60) @(posedge clk_sys_i);
    #1;
  endtask

  // low five bits of the fourth byte are undetermined
  task automatic get(input int n, input logic [31:0] exp);
    mst_u.fetch(8'h51, n, ack, d);
    chk(ack, 1'b1);
    chk(d & ((n == 4) ? 32'hffff_ffe0 : 32'hffff_ffff), exp >> (8 * (4 - n)));
  endtask

  task automatic do_reset();
    @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    #1;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_fresh();
    get(4, pk(2'h2));
    meas(14'h2a5c, 11'h5b3);
    get(4, pk(2'h0));
    get(2, pk(2'h2));
    get(3, pk(2'h2));
    meas(14'h15a3, 11'h24c);
    get(3, pk(2'h0));
    cmd_mode_i = 1'b1;
    meas(14'h3fff, 11'h7ff);
    get(2, pk(2'h1));
    cmd_mode_i = 1'b0;
  endtask

  task automatic t_addr();
    logic [7:0] bad [3] = '{8'h53, 8'h50, 8'hd1};
    foreach (bad[i]) begin
      mst_u.fetch(bad[i], 2, ack, d);
      chk(ack, 1'b0);
    end
    get(2, pk(2'h2));
  endtask

  task automatic t_faulty_start();
    logic x;
    mst_u.bare_start_stop();
    mst_u.fetch(8'h51, 2, ack, d);
    chk(ack, 1'b0);
    get(2, pk(2'h2));
    mst_u.start();
    for (int i = 7; i > 3; i--) begin
      mst_u.bit_xfer(i[0], x);
    end
    mst_u.start();
    mst_u.xfer_byte(8'h51, d[7:0]);
    mst_u.bit_xfer(1'b1, x);
    mst_u.stop();
    mst_u.fetch(8'h51, 2, ack, d);
    chk(ack, 1'b0);
    get(2, pk(2'h2));
  endtask

  // fifo backs up while a fetch holds the link side busy
  task automatic t_fill();
    int n;
    n = 0;
    fork
      mst_u.fetch(8'h51, 4, ack, d);
      begin
        repeat (200) @(posedge clk_sys_i);
        for (int i = 0; i < 20; i++) begin
          push(14'h1000 + 14'(i), 11'h100 + 11'(i), tk);
          n += int'(tk === 1'b1);
        end
      end
    join
    chk(d & 32'hffff_ffe0, pk(2'h2));
    chk(n > 15 && n < 18, 1'b1);
    chk(tk, 1'b0);
    repeat (1000) @(posedge clk_sys_i);
    chk(meas_ready_o, 1'b1);
    lp = 14'h1000 + 14'(n - 1);
    lt = 11'h100 + 11'(n - 1);
    get(4, pk(2'h0));
  endtask

  task automatic t_diag();
    for (int k = 0; k < 4; k++) begin
      do_reset();
      lp = 14'h0000;
      lt = 11'h000;
      fault = 4'h1 << k;
      get(2, pk(2'h2));
      meas(14'h0a00 + 14'(k), 11'h0c0);
      get(2, pk(2'h3));
      fault = 4'h0;
      meas(14'h0b00, 11'h0d0);
      get(4, pk(2'h3));
    end
    // a fault still present after reset latches again
    fault = 4'h8;
    do_reset();
    meas(14'h0c10, 11'h0e1);
    get(2, pk(2'h3));
    fault = 4'h0;
    do_reset();
    meas(14'h0c00, 11'h0e0);
    get(2, pk(2'h0));
  endtask

  // ----------------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------------
  task automatic results();
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    t_fresh();
    t_addr();
    t_faulty_start();
    t_fill();
    t_diag();
    results();
  end

  // about 2.8 ms of fetches are expected; limit stays under 100k cycles
  initial begin
    #3_800_000;
    n_errors++;
    results();
  end
endmodule // tb
